/* logic/cssc_top.sv */
`timescale 1ns/1ns
// What this block does
// - Divider code n divides by 2**n for 0..9; codes 10..15 reserved.
// - Hold bit set: ready new source is held, not switched, and interrupt raised.
// - Hold bit clear: pending switch completes once new source ready, with interrupt.
// - Power select gives high or low secondary power; ignored while bypassed.
// - Bypass set: secondary input is external clock; clear: both pins form crystal.
// - Switch-done flag reads 1 when requested equals current, 0 during switch.
// - New-source-ready flag reads 1 only while switch pending and new source ready.
// - Source codes 7 ext, 6 fast, 4 slow, 3 secondary, 1 ext PLL, 0 fast PLL.
// - Writing a reserved source code selects the fast internal oscillator.
module cssc_top #(
   parameter int ADDR_W = 8,
   parameter logic [2:0] RESET_SOURCE = cssc_pkg::RST_SRC,
   parameter logic [3:0] RESET_DIVIDER = cssc_pkg::RST_DIV
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic external_osc_ok_i,
   input wire logic fast_internal_osc_ok_i,
   input wire logic slow_internal_osc_ok_i,
   input wire logic secondary_osc_ok_i,
   input wire logic converter_rc_osc_ok_i,
   input wire logic pll_lock_i,
   input wire logic [cssc_pkg::OSC_N-1:0] osc_request_i,
   output logic [cssc_pkg::OSC_N-1:0] osc_enable_o,
   output logic pll_enable_o,
   output logic [2:0] sys_source_o,
   output logic [3:0] sys_divider_o,
   output logic secondary_high_power_o,
   output logic secondary_ext_clock_o,
   output logic secondary_xtal_en_o,
   output logic irq_o
);

   typedef struct packed {
      logic [2:0] req_src;
      logic [3:0] req_div;
      logic [2:0] cur_src;
      logic [3:0] cur_div;
      logic hold;
      logic pwr;
      logic bypass;
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [cssc_pkg::EV_W-1:0] stat;
      logic [cssc_pkg::EV_W-1:0] mask;
      logic held_seen;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic [cssc_pkg::OSC_N-1:0] osc_en;
      logic pll_en;
      logic hi_pwr;
      logic ext_clk;
      logic xtal_en;
   } cssc_state_s;

   cssc_state_s s_q;
   cssc_state_s s_d;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Oscillators a source code depends on
   function automatic logic [cssc_pkg::OSC_N-1:0] src_needs(input logic [2:0] code);
      logic [cssc_pkg::OSC_N-1:0] n;
      n = '0;
      unique case (code)
         cssc_pkg::SRC_EXT, cssc_pkg::SRC_EXT_PLL: n[cssc_pkg::OSC_EXT] = 1'b1;
         cssc_pkg::SRC_FAST, cssc_pkg::SRC_FAST_PLL: n[cssc_pkg::OSC_FAST] = 1'b1;
         cssc_pkg::SRC_SLOW: n[cssc_pkg::OSC_SLOW] = 1'b1;
         cssc_pkg::SRC_SEC: n[cssc_pkg::OSC_SEC] = 1'b1;
         default: n = '0;
      endcase
      return n;
   endfunction

   // Source code uses the PLL
   function automatic logic src_pll(input logic [2:0] code);
      return (code == cssc_pkg::SRC_EXT_PLL) || (code == cssc_pkg::SRC_FAST_PLL);
   endfunction

   // Source code is a reserved value
   function automatic logic src_rsv(input logic [2:0] code);
      return (code == cssc_pkg::SRC_RSV_HI) || (code == cssc_pkg::SRC_RSV_LO);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Readiness and switch status

   logic [cssc_pkg::OSC_N-1:0] osc_rdy;
   logic pll_in_rdy;
   logic pll_rdy;
   logic req_rdy;
   logic pending;
   logic new_ready;
   logic switch_done;
   logic ev_done;
   logic ev_held;
   logic setup;
   logic access;
   logic [7:0] addr;
   logic [7:0] ctrl3_rd;
   logic [7:0] rdy_rd;

   // Ready only when enabled and the oscillator reports good
   assign osc_rdy = s_q.osc_en & s_q.sync2[cssc_pkg::OSC_N-1:0];
   // PLL input is external for the ext PLL code, otherwise fast internal
   assign pll_in_rdy = (src_pll(s_q.req_src) ? s_q.req_src : s_q.cur_src) == cssc_pkg::SRC_EXT_PLL ?
                       osc_rdy[cssc_pkg::OSC_EXT] : osc_rdy[cssc_pkg::OSC_FAST];
   assign pll_rdy = s_q.pll_en & pll_in_rdy & s_q.sync2[5];
   // Requested source usable
   assign req_rdy = src_pll(s_q.req_src) ? pll_rdy : |(src_needs(s_q.req_src) & osc_rdy);
   assign pending = (s_q.req_src != s_q.cur_src) || (s_q.req_div != s_q.cur_div);
   assign new_ready = pending & req_rdy;
   assign switch_done = !pending;
   assign ev_done = new_ready & !s_q.hold;
   assign ev_held = new_ready & s_q.hold & !s_q.held_seen;

   // Bus phases
   assign setup = psel_i & !penable_i;
   assign access = psel_i & penable_i & s_q.pready;
   assign addr = 8'(paddr_i);

   // Read views of the status registers
   always_comb begin
      ctrl3_rd = 8'h00;
      ctrl3_rd[cssc_pkg::HOLD_BIT] = s_q.hold;
      ctrl3_rd[cssc_pkg::PWR_BIT] = s_q.pwr;
      ctrl3_rd[cssc_pkg::BYP_BIT] = s_q.bypass;
      ctrl3_rd[cssc_pkg::DONE_BIT] = switch_done;
      ctrl3_rd[cssc_pkg::NEWR_BIT] = new_ready;
      rdy_rd = 8'h00;
      rdy_rd[cssc_pkg::EXT_RDY_BIT] = osc_rdy[cssc_pkg::OSC_EXT];
      rdy_rd[cssc_pkg::FAST_RDY_BIT] = osc_rdy[cssc_pkg::OSC_FAST];
      rdy_rd[cssc_pkg::SLOW_RDY_BIT] = osc_rdy[cssc_pkg::OSC_SLOW];
      rdy_rd[cssc_pkg::SEC_RDY_BIT] = osc_rdy[cssc_pkg::OSC_SEC];
      rdy_rd[cssc_pkg::CONV_RDY_BIT] = osc_rdy[cssc_pkg::OSC_CONV];
      rdy_rd[cssc_pkg::PLL_RDY_BIT] = pll_rdy;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d = s_q;
      // Two-stage synchronisers for oscillator status pins
      s_d.sync1 = {pll_lock_i, converter_rc_osc_ok_i, secondary_osc_ok_i,
                   slow_internal_osc_ok_i, fast_internal_osc_ok_i, external_osc_ok_i};
      s_d.sync2 = s_q.sync1;
      // Switch completion copies request into current
      if (ev_done) begin
         s_d.cur_src = s_q.req_src;
         s_d.cur_div = s_q.req_div;
      end
      s_d.held_seen = new_ready & s_q.hold;
      // Bus answer one cycle after setup
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (setup) begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         unique case (addr)
            cssc_pkg::OFF_CTRL1: s_d.prdata[6:0] = {s_q.req_src, s_q.req_div};
            cssc_pkg::OFF_CTRL2: s_d.prdata[6:0] = {s_q.cur_src, s_q.cur_div};
            cssc_pkg::OFF_CTRL3: s_d.prdata[7:0] = ctrl3_rd;
            cssc_pkg::OFF_RDY: s_d.prdata[7:0] = rdy_rd;
            cssc_pkg::OFF_ISTAT: s_d.prdata[cssc_pkg::EV_W-1:0] = s_q.stat;
            cssc_pkg::OFF_IMASK: s_d.prdata[cssc_pkg::EV_W-1:0] = s_q.mask;
            default: s_d.pslverr = 1'b1;
         endcase
      end
      // Register writes take effect at the access edge
      s_d.stat = s_q.stat;
      if (access && pwrite_i) begin
         unique case (addr)
            cssc_pkg::OFF_CTRL1: begin
               // Reserved source falls back to fast internal
               s_d.req_src = src_rsv(pwdata_i[cssc_pkg::SRC_LSB +: 3]) ? cssc_pkg::SRC_FAST
                             : pwdata_i[cssc_pkg::SRC_LSB +: 3];
               // Reserved divider codes are not accepted
               if (pwdata_i[cssc_pkg::DIV_LSB +: 4] <= cssc_pkg::DIV_MAX) begin
                  s_d.req_div = pwdata_i[cssc_pkg::DIV_LSB +: 4];
               end
            end
            cssc_pkg::OFF_CTRL3: begin
               s_d.hold = pwdata_i[cssc_pkg::HOLD_BIT];
               s_d.pwr = pwdata_i[cssc_pkg::PWR_BIT];
               s_d.bypass = pwdata_i[cssc_pkg::BYP_BIT];
            end
            cssc_pkg::OFF_ISTAT: s_d.stat = s_q.stat & ~pwdata_i[cssc_pkg::EV_W-1:0];
            cssc_pkg::OFF_IMASK: s_d.mask = pwdata_i[cssc_pkg::EV_W-1:0];
            default: s_d.stat = s_q.stat;
         endcase
      end
      // Events set over a simultaneous clear
      s_d.stat[cssc_pkg::EV_DONE_BIT] = s_d.stat[cssc_pkg::EV_DONE_BIT] | ev_done;
      s_d.stat[cssc_pkg::EV_HELD_BIT] = s_d.stat[cssc_pkg::EV_HELD_BIT] | ev_held;
      s_d.irq = |(s_d.stat & s_d.mask);
      // Oscillator and PLL enables follow current and requested sources
      s_d.osc_en = src_needs(s_q.cur_src) | src_needs(s_q.req_src) | osc_request_i;
      s_d.pll_en = src_pll(s_q.cur_src) | src_pll(s_q.req_src);
      // Secondary oscillator pin mode
      s_d.hi_pwr = s_q.pwr & !s_q.bypass;
      s_d.ext_clk = s_q.bypass;
      s_d.xtal_en = !s_q.bypass;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_q <= '0;
         s_q.req_src <= RESET_SOURCE;
         s_q.req_div <= RESET_DIVIDER;
         s_q.cur_src <= RESET_SOURCE;
         s_q.cur_div <= RESET_DIVIDER;
         s_q.hold <= cssc_pkg::RST_CTRL3[cssc_pkg::HOLD_BIT];
         s_q.pwr <= cssc_pkg::RST_CTRL3[cssc_pkg::PWR_BIT];
         s_q.bypass <= cssc_pkg::RST_CTRL3[cssc_pkg::BYP_BIT];
         s_q.xtal_en <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign prdata_o = s_q.prdata;
   assign pready_o = s_q.pready;
   assign pslverr_o = s_q.pslverr;
   assign osc_enable_o = s_q.osc_en;
   assign pll_enable_o = s_q.pll_en;
   assign sys_source_o = s_q.cur_src;
   assign sys_divider_o = s_q.cur_div;
   assign secondary_high_power_o = s_q.hi_pwr;
   assign secondary_ext_clock_o = s_q.ext_clk;
   assign secondary_xtal_en_o = s_q.xtal_en;
   assign irq_o = s_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   a_div_code_legal: assert property (s_q.req_div <= cssc_pkg::DIV_MAX && s_q.cur_div <= cssc_pkg::DIV_MAX)
      else $error("divider code outside legal range");

   a_hold_keeps_src: assert property (s_q.hold && new_ready |=> s_q.cur_src == $past(s_q.cur_src)
      && s_q.cur_div == $past(s_q.cur_div))
      else $error("held switch changed current source");

   a_hold_raises_irq: assert property (ev_held |=> s_q.stat[1])
      else $error("held switch did not flag interrupt");

   a_switch_completes: assert property (!s_q.hold && new_ready |=> s_q.cur_src == $past(s_q.req_src)
      && s_q.stat[0])
      else $error("ready switch did not complete");

   a_power_mode: assert property (##1 secondary_high_power_o == $past(s_q.pwr && !s_q.bypass))
      else $error("secondary power mode wrong");

   a_bypass_pins: assert property (##1 secondary_xtal_en_o == !secondary_ext_clock_o
      && secondary_ext_clock_o == $past(s_q.bypass))
      else $error("secondary pin mode wrong");

   a_done_read: assert property (setup && addr == cssc_pkg::OFF_CTRL3 |=> prdata_o[cssc_pkg::DONE_BIT]
      == $past(!pending))
      else $error("switch done flag read wrong");

   a_new_ready_flag: assert property (new_ready |-> pending && !switch_done)
      else $error("new ready flag outside a switch");

   a_pll_ready: assert property (pll_rdy |-> s_q.pll_en && s_q.sync2[5])
      else $error("pll ready without enable or lock");

   a_src_ready: assert property ((osc_rdy & ~s_q.osc_en) == '0)
      else $error("ready bit on disabled oscillator");

   a_no_rsv_src: assert property (!src_rsv(s_q.req_src) && !src_rsv(s_q.cur_src))
      else $error("reserved source code stored");

   a_rsv_write_fast: assert property (access && pwrite_i && addr == cssc_pkg::OFF_CTRL1
      && src_rsv(pwdata_i[cssc_pkg::SRC_LSB +: 3]) |=> s_q.req_src == cssc_pkg::SRC_FAST)
      else $error("reserved write did not select fast internal");

   ////////////////////////////////////////////////////////////////////////////
   // Switch ordering and read-view checks

   // Held event flags only once per unbroken run of new-source-ready under hold
   a_held_once: assert property (ev_held |=> !ev_held)
      else $error("held event flagged twice");

   // Completion raises the level interrupt when unmasked
   a_done_sets_irq: assert property (ev_done && s_q.mask[cssc_pkg::EV_DONE_BIT] && !(access && pwrite_i)
      |=> irq_o)
      else $error("switch done did not raise interrupt");

   // Reserved divider write leaves the request alone
   a_div_reserved_kept: assert property (access && pwrite_i && addr == cssc_pkg::OFF_CTRL1
      && pwdata_i[cssc_pkg::DIV_LSB +: 4] > cssc_pkg::DIV_MAX |=> s_q.req_div == $past(s_q.req_div))
      else $error("reserved divider write changed request");

   // New-source-ready flag on the bus
   a_new_ready_read: assert property (setup && addr == cssc_pkg::OFF_CTRL3 |=> prdata_o[cssc_pkg::NEWR_BIT]
      == $past(new_ready))
      else $error("new ready flag read wrong");

   // PLL ready flag on the bus
   a_pll_read: assert property (setup && addr == cssc_pkg::OFF_RDY |=> prdata_o[cssc_pkg::PLL_RDY_BIT]
      == $past(pll_rdy))
      else $error("pll ready read wrong");

   // Slow source ready flag on the bus
   a_src_read: assert property (setup && addr == cssc_pkg::OFF_RDY |=> prdata_o[cssc_pkg::SLOW_RDY_BIT]
      == $past(osc_rdy[cssc_pkg::OSC_SLOW]))
      else $error("source ready read wrong");

   // Bypass forces low power whatever the select bit
   a_bypass_no_power: assert property (s_q.bypass |=> !secondary_high_power_o)
      else $error("power select honoured while bypassed");

   // Current clock changes only on a ready, unheld switch
   a_switch_needs_ready: assert property ($changed(s_q.cur_src) || $changed(s_q.cur_div)
      |-> $past(new_ready && !s_q.hold))
      else $error("current clock changed without ready source");

   // No switch under way keeps the current clock
   a_idle_stable: assert property (!pending |=> $stable(s_q.cur_src)
      && $stable(s_q.cur_div))
      else $error("current clock moved with no switch pending");

   // Main scenarios reached
   c_switch_done: cover property (ev_done ##1 irq_o);
   c_switch_held: cover property (ev_held ##[1:20] ev_done);
   c_read_status: cover property (setup && addr == cssc_pkg::OFF_RDY ##1 pready_o);
   c_rsv_write: cover property (access && pwrite_i && addr == cssc_pkg::OFF_CTRL1 && src_rsv(pwdata_i[6:4]));
   c_pll_switch: cover property (ev_done && src_pll(s_q.req_src));

endmodule

/* logic/cssc_pkg.sv */
package cssc_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_CTRL3 = 8'h08;
   localparam logic [7:0] OFF_RDY = 8'h0C;
   localparam logic [7:0] OFF_ISTAT = 8'h10;
   localparam logic [7:0] OFF_IMASK = 8'h14;

   // Field positions in the source/divider registers
   localparam int SRC_LSB = 4;
   localparam int DIV_LSB = 0;

   // Field positions in clock_switch_control_3
   localparam int HOLD_BIT = 7;
   localparam int PWR_BIT = 6;
   localparam int BYP_BIT = 5;
   localparam int DONE_BIT = 4;
   localparam int NEWR_BIT = 3;

   // Field positions in oscillator_ready_status
   localparam int EXT_RDY_BIT = 7;
   localparam int FAST_RDY_BIT = 6;
   localparam int SLOW_RDY_BIT = 4;
   localparam int SEC_RDY_BIT = 3;
   localparam int CONV_RDY_BIT = 2;
   localparam int PLL_RDY_BIT = 0;

   // Interrupt status bits
   localparam int EV_DONE_BIT = 0;
   localparam int EV_HELD_BIT = 1;
   localparam int EV_W = 2;

   // Oscillator index in ready and enable vectors
   localparam int OSC_EXT = 0;
   localparam int OSC_FAST = 1;
   localparam int OSC_SLOW = 2;
   localparam int OSC_SEC = 3;
   localparam int OSC_CONV = 4;
   localparam int OSC_N = 5;

   // Source codes
   localparam logic [2:0] SRC_EXT = 3'h7;
   localparam logic [2:0] SRC_FAST = 3'h6;
   localparam logic [2:0] SRC_RSV_HI = 3'h5;
   localparam logic [2:0] SRC_SLOW = 3'h4;
   localparam logic [2:0] SRC_SEC = 3'h3;
   localparam logic [2:0] SRC_RSV_LO = 3'h2;
   localparam logic [2:0] SRC_EXT_PLL = 3'h1;
   localparam logic [2:0] SRC_FAST_PLL = 3'h0;

   // Divider codes: 2**code, highest legal code divides by 512
   localparam logic [3:0] DIV_MAX = 4'h9;

   // Reset values
   localparam logic [2:0] RST_SRC = SRC_FAST;
   localparam logic [3:0] RST_DIV = 4'h2;
   localparam logic [7:0] RST_CTRL3 = 8'h00;

endpackage

/* bench/cssc_tb.sv */
`timescale 1ns/1ns
module testbench;
   logic clk, rst, psel, pen, pwr, pready, pslverr, pll_en, hp, extc, xtal, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] ok;
   logic [4:0] osc_req, osc_en;
   logic [2:0] src, s;
   logic [3:0] dv, d, exp_div;
   logic [2:0] legal [4] = '{3'h7, 3'h6, 3'h4, 3'h3};
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 97;

   cssc_top dut_u (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .external_osc_ok_i(ok[0]), .fast_internal_osc_ok_i(ok[1]), .slow_internal_osc_ok_i(ok[2]),
      .secondary_osc_ok_i(ok[3]), .converter_rc_osc_ok_i(ok[4]), .pll_lock_i(ok[5]),
      .osc_request_i(osc_req), .osc_enable_o(osc_en), .pll_enable_o(pll_en), .sys_source_o(src),
      .sys_divider_o(dv), .secondary_high_power_o(hp), .secondary_ext_clock_o(extc),
      .secondary_xtal_en_o(xtal), .irq_o(irq));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #(50 * 5000);
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high or 20 cycles have passed
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk(32'h0, 32'h1, "pready timeout");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Read a register and compare it
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e, "register read");
   endtask

   // Poll the current source and divider under a bounded count
   task automatic wait_cur(input logic [6:0] e);
      int n;
      n = 0;
      while ({src, dv} !== e && n < 30) begin
         @(posedge clk);
         n++;
      end
      chk({25'h0, src, dv}, {25'h0, e}, "current clock");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ok = 6'h3F;
      osc_req = 5'h00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(8'h04, 32'h00000062);
      rchk(8'h08, 32'h00000010);
      chk({26'h0, pll_en, osc_en}, 32'h2, "enables after reset");
      rchk(8'h18, 32'h00000000);
      chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, 8'h14, 32'h3);
      // Random switches with legal and reserved dividers
      exp_div = 4'h2;
      for (int i = 0; i < 14; i++) begin
         s = (i == 0) ? 3'h7 : legal[($random(seed) & 3)];
         d = (i == 0) ? 4'h9 : (i == 1) ? 4'hA : 4'($random(seed));
         if (d <= 4'h9) exp_div = d;
         apb(1'b1, 8'h00, {25'h0, s, d});
         wait_cur({s, exp_div});
      end
      rchk(8'h10, 32'h00000001);
      chk({31'h0, irq}, 32'h1, "irq after switch");
      apb(1'b1, 8'h10, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      // Reserved source codes fall back to the fast internal source
      apb(1'b1, 8'h00, 32'h53);
      rchk(8'h00, 32'h00000063);
      wait_cur(7'h63);
      apb(1'b1, 8'h00, 32'h24);
      rchk(8'h00, 32'h00000064);
      wait_cur(7'h64);
      apb(1'b1, 8'h10, 32'h3);
      // Held switch to the slow source
      apb(1'b1, 8'h08, 32'h80);
      ok[2] <= 1'b0;
      apb(1'b1, 8'h00, 32'h43);
      rchk(8'h08, 32'h00000080);
      ok[2] <= 1'b1;
      repeat (10) @(posedge clk);
      chk({29'h0, src}, 32'h6, "source during hold");
      rchk(8'h08, 32'h00000088);
      rchk(8'h10, 32'h00000002);
      chk({31'h0, irq}, 32'h1, "irq on hold");
      apb(1'b1, 8'h08, 32'h0);
      wait_cur(7'h43);
      rchk(8'h08, 32'h00000010);
      rchk(8'h10, 32'h00000003);
      // Secondary power and bypass
      apb(1'b1, 8'h08, 32'h40);
      repeat (2) @(posedge clk);
      chk({29'h0, hp, extc, xtal}, 32'h5, "secondary crystal high power");
      apb(1'b1, 8'h08, 32'h60);
      repeat (2) @(posedge clk);
      chk({29'h0, hp, extc, xtal}, 32'h2, "secondary bypass");
      // Per-source ready status
      osc_req <= 5'h1F;
      repeat (6) @(posedge clk);
      rchk(8'h0C, 32'h000000DC);
      ok[0] <= 1'b0;
      repeat (6) @(posedge clk);
      rchk(8'h0C, 32'h0000005C);
      ok[0] <= 1'b1;
      // Switch to the fast source with PLL
      apb(1'b1, 8'h00, 32'h02);
      wait_cur(7'h02);
      chk({26'h0, pll_en, osc_en}, 32'h3F, "enables on pll source");
      repeat (4) @(posedge clk);
      rchk(8'h0C, 32'h000000DD);
      ok[5] <= 1'b0;
      repeat (6) @(posedge clk);
      rchk(8'h0C, 32'h000000DC);
      test_done;
   end
endmodule
